// ===== inc/tmr_regs.vh
// Register map, field positions and reset values of the 16-bit timer/counter.
// Assumes a 32-bit APB slave; every register is one aligned word, data in the low byte.
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// Byte offsets on the APB
`define TMR_CTRL_OFF 12'h000
`define TMR_CNTL_OFF 12'h004
`define TMR_CNTH_OFF 12'h008
`define TMR_ISTAT_OFF 12'h00c
`define TMR_ICLR_OFF 12'h010
`define TMR_IEN_OFF 12'h014

// Control field positions
`define TMR_B_WIDE 7
`define TMR_B_RUN 6
`define TMR_B_PS_HI 5
`define TMR_B_PS_LO 4
`define TMR_B_OSCEN 3
`define TMR_B_BYP 2
`define TMR_B_SRC 1
`define TMR_B_ON 0

// Interrupt status bit of the overflow event
`define TMR_B_OVF 0

// Reset values and limits
`define TMR_CTRL_RST 8'h00
`define TMR_CTRL_WMASK 8'hbf
`define TMR_CNT_RST 16'h0000
`define TMR_CNT_MAX 16'hffff
`define TMR_HBUF_RST 8'h00

// Instruction clock is the system clock divided by four
`define TMR_FOSC_DIV 4
`define TMR_FDIV_LAST 2'h3

`endif

// ===== logic/tmr_pin_sync.v
// Three-stage pin synchroniser with an agreement filter.
// Assumes din is asynchronous to clk; ce freezes every stage.
`timescale 1ns/100ps
module tmr_pin_sync
(
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire din,
   output wire fast,
   output reg level
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // First stage feeds only the second; level moves once stages 2 and 3 agree
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level <= 1'b0;
      end
      else if (ce)
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            level <= s3_reg;
      end
   end

   // Unfiltered view, two cycles earlier than level
   assign fast = s2_reg;

endmodule // tmr_pin_sync

// ===== logic/tmr_prescale.v
// Hidden prescale counter: passes one of every 1, 2, 4 or 8 input ticks.
// Assumes tick is a one-cycle pulse on clk; clear wins over a tick.
`timescale 1ns/100ps
module tmr_prescale
(
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire tick,
   input wire clear,
   input wire [1:0] sel,
   output wire out_tick
);
   reg [2:0] cnt_reg;
   reg [2:0] mask;

   // Code 11 -> 1:8, 10 -> 1:4, 01 -> 1:2, 00 -> every tick
   always @*
   begin
      case (sel)
         2'h3: mask = 3'h7;
         2'h2: mask = 3'h3;
         2'h1: mask = 3'h1;
         default: mask = 3'h0;
      endcase
   end

   assign out_tick = tick && ((cnt_reg & mask) == mask) && !clear;

   // Low-byte write, or high write in byte mode, clears the prescaler so the next period is whole
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= 3'h0;
      else if (ce)
      begin
         if (clear)
            cnt_reg <= 3'h0;
         else if (tick)
            cnt_reg <= cnt_reg + 3'h1;
      end
   end

endmodule // tmr_prescale

// ===== logic/tmr_timer_top.v
// Top of the 16-bit timer/counter: APB registers, source select, counter, interrupt.
// Assumes one system clock pclk; pins arrive asynchronously and are synchronised here.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "tmr_regs.vh"
module tmr_timer_top
(
   input wire pclk,
   input wire presetn,
   input wire pce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output wire irq,
   input wire sysclk_from_osc,
   input wire external_count_input,
   input wire osc_input_pin,
   input wire [1:0] port_c_direction,
   input wire [1:0] port_c_out,
   output wire pin0_out,
   output wire pin0_oe,
   output wire pin1_out,
   output wire pin1_oe,
   output wire osc_amp_enable,
   output wire [1:0] port_c_read
);
   reg [7:0] ctrl_reg;
   reg [15:0] count_reg;
   reg [15:0] count_next;
   reg [7:0] hbuf_reg;
   reg [7:0] hbuf_next;
   reg [1:0] fdiv_reg;
   reg src_prev_reg;
   reg need_fall_reg;
   reg high_at_off_reg;
   reg ovf_stat_reg;
   reg ovf_en_reg;
   reg [7:0] rd_byte;
   reg addr_ok;

   wire access;
   wire wr_done;
   wire rd_start;
   wire wr_ctrl;
   wire wr_low;
   wire wr_high;
   wire wr_iclr;
   wire wr_ien;
   wire rd_low;
   wire wide_access_enable;
   wire [1:0] input_prescale_select;
   wire low_power_osc_enable;
   wire ext_sync_bypass;
   wire clock_source_select;
   wire counter_on;
   wire ext_fast;
   wire ext_level;
   wire osc_fast;
   wire osc_level;
   wire src_fast;
   wire src_filt;
   wire src_level;
   wire src_rise;
   wire src_fall;
   wire int_tick;
   wire pre_tick;
   wire pre_clear;
   wire inc;
   wire count_wr;
   wire overflow;
   wire turn_on;
   wire turn_off;

   // Control fields
   assign wide_access_enable = ctrl_reg[`TMR_B_WIDE];
   assign input_prescale_select = ctrl_reg[`TMR_B_PS_HI:`TMR_B_PS_LO];
   assign low_power_osc_enable = ctrl_reg[`TMR_B_OSCEN];
   assign ext_sync_bypass = ctrl_reg[`TMR_B_BYP];
   assign clock_source_select = ctrl_reg[`TMR_B_SRC];
   assign counter_on = ctrl_reg[`TMR_B_ON];

   // APB phases; reads sample in the first access cycle, writes land on completion
   assign access = psel && penable;
   assign wr_done = access && pready && pwrite && addr_ok;
   assign rd_start = access && !pready && !pwrite;
   assign wr_ctrl = wr_done && (paddr == `TMR_CTRL_OFF);
   assign wr_low = wr_done && (paddr == `TMR_CNTL_OFF);
   assign wr_high = wr_done && (paddr == `TMR_CNTH_OFF);
   assign wr_iclr = wr_done && (paddr == `TMR_ICLR_OFF);
   assign wr_ien = wr_done && (paddr == `TMR_IEN_OFF);
   assign rd_low = rd_start && (paddr == `TMR_CNTL_OFF);

   // Address decode; anything else answers with pslverr
   always @*
   begin
      case (paddr)
         `TMR_CTRL_OFF: addr_ok = 1'b1;
         `TMR_CNTL_OFF: addr_ok = 1'b1;
         `TMR_CNTH_OFF: addr_ok = 1'b1;
         `TMR_ISTAT_OFF: addr_ok = 1'b1;
         `TMR_ICLR_OFF: addr_ok = 1'b1;
         `TMR_IEN_OFF: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read mux; the run bit shows the live clock-source status
   always @*
   begin
      case (paddr)
         `TMR_CTRL_OFF:
            rd_byte = {ctrl_reg[7], sysclk_from_osc, ctrl_reg[5:0]};
         `TMR_CNTL_OFF:
            rd_byte = count_reg[7:0];
         `TMR_CNTH_OFF:
            rd_byte = wide_access_enable ? hbuf_reg : count_reg[15:8];
         `TMR_ISTAT_OFF:
            rd_byte = {7'h00, ovf_stat_reg};
         `TMR_IEN_OFF:
            rd_byte = {7'h00, ovf_en_reg};
         default:
            rd_byte = 8'h00;
      endcase
   end

   // One wait state: ready one cycle after the access phase opens
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (pce)
      begin
         pready <= access && !pready;
         pslverr <= access && !pready && !addr_ok;
         if (rd_start)
            prdata <= {24'h000000, rd_byte};
      end
   end

   // Control register; the status bit is never stored
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= `TMR_CTRL_RST;
      else if (pce && wr_ctrl)
         ctrl_reg <= pwdata[7:0] & `TMR_CTRL_WMASK;
   end

   // Oscillator amplifier only while enabled, saves power when off
   assign osc_amp_enable = low_power_osc_enable;

   // Oscillator steals both pins: no digital drive, reads as zero
   assign pin0_out = port_c_out[0];
   assign pin1_out = port_c_out[1];
   assign pin0_oe = !low_power_osc_enable && !port_c_direction[0];
   assign pin1_oe = !low_power_osc_enable && !port_c_direction[1];
   assign port_c_read = low_power_osc_enable ? 2'h0 : {osc_level, ext_level};

   // Pin synchronisers for the count input and the oscillator input
   tmr_pin_sync u_ext_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .ce(pce),
      .din(external_count_input),
      .fast(ext_fast),
      .level(ext_level)
   );

   tmr_pin_sync u_osc_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .ce(pce),
      .din(osc_input_pin),
      .fast(osc_fast),
      .level(osc_level)
   );

   // External source is the oscillator when enabled, else the count pin
   assign src_fast = low_power_osc_enable ? osc_fast : ext_fast;
   assign src_filt = low_power_osc_enable ? osc_level : ext_level;
   // Bypass trades glitch filtering for two cycles less latency
   assign src_level = ext_sync_bypass ? src_fast : src_filt;
   assign src_rise = src_level && !src_prev_reg;
   assign src_fall = !src_level && src_prev_reg;

   // Edge history and the instruction-clock divider
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_prev_reg <= 1'b0;
         fdiv_reg <= 2'h0;
      end
      else if (pce)
      begin
         src_prev_reg <= src_level;
         fdiv_reg <= fdiv_reg + 2'h1;
      end
   end

   assign int_tick = (fdiv_reg == `TMR_FDIV_LAST);

   // Enable edges, as written by software
   assign turn_on = wr_ctrl && pwdata[`TMR_B_ON] && !counter_on;
   assign turn_off = wr_ctrl && !pwdata[`TMR_B_ON] && counter_on;
   assign count_wr = wr_low || wr_high;

   // Falling edge must be seen before the first counted rising edge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         need_fall_reg <= 1'b1;
         high_at_off_reg <= 1'b0;
      end
      else if (pce)
      begin
         if (turn_off)
            high_at_off_reg <= src_level;
         if (count_wr || (turn_on && !src_level && high_at_off_reg))
            need_fall_reg <= 1'b1;
         else if (src_fall)
            need_fall_reg <= 1'b0;
      end
   end

   // Source select, gated by the on bit
   assign pre_tick = counter_on &&
      (clock_source_select ? (src_rise && !need_fall_reg) : int_tick);
   // Wide-mode high write only fills the buffer, so the prescaler keeps running
   assign pre_clear = wr_low || (wr_high && !wide_access_enable);

   tmr_prescale u_prescale
   (
      .clk(pclk),
      .rst_n(presetn),
      .ce(pce),
      .tick(pre_tick),
      .clear(pre_clear),
      .sel(input_prescale_select),
      .out_tick(inc)
   );

   // A count write wins over a coinciding increment
   assign overflow = inc && !count_wr && (count_reg == `TMR_CNT_MAX);

   // Count and high-byte buffer next state
   always @*
   begin
      count_next = count_reg;
      hbuf_next = hbuf_reg;
      if (wr_low)
      begin
         count_next[7:0] = pwdata[7:0];
         if (wide_access_enable)
            count_next[15:8] = hbuf_reg;
      end
      else if (wr_high)
      begin
         if (wide_access_enable)
            hbuf_next = pwdata[7:0];
         else
            count_next[15:8] = pwdata[7:0];
      end
      else if (inc)
         count_next = count_reg + 16'h0001;
      if (rd_low && wide_access_enable)
         hbuf_next = count_reg[15:8];
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_reg <= `TMR_CNT_RST;
         hbuf_reg <= `TMR_HBUF_RST;
      end
      else if (pce)
      begin
         count_reg <= count_next;
         hbuf_reg <= hbuf_next;
      end
   end

   // Sticky overflow flag; a new overflow beats a clear in the same cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovf_stat_reg <= 1'b0;
         ovf_en_reg <= 1'b0;
      end
      else if (pce)
      begin
         if (overflow)
            ovf_stat_reg <= 1'b1;
         else if (wr_iclr && pwdata[`TMR_B_OVF])
            ovf_stat_reg <= 1'b0;
         if (wr_ien)
            ovf_en_reg <= pwdata[`TMR_B_OVF];
      end
   end

   // Level interrupt while an enabled flag stands
   assign irq = ovf_stat_reg && ovf_en_reg;

endmodule // tmr_timer_top

// ===== testbench/tmr_timer_properties.sv
// Port-level checker for the timer top: APB timing, pin gating, status bit.
// Assumes it is bound to tmr_timer_top; sees only the top's ports.
`timescale 1ns/100ps
module tmr_timer_props
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire sysclk_from_osc,
   input wire [1:0] port_c_direction,
   input wire pin0_oe,
   input wire pin1_oe,
   input wire osc_amp_enable,
   input wire [1:0] port_c_read
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // One wait state, then a single-cycle answer
   wait_state_a: assert property ($rose(penable) && psel |=> pready ##1 !pready)
      else $error("pready not one cycle after first access cycle");
   err_decode_a: assert property (pready |-> pslverr == (paddr > 12'h014))
      else $error("pslverr does not match address decode");
   read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   // Status bit mirrors the live input sampled at the first access edge
   status_bit_a: assert property (pready && !pwrite && paddr == 12'h000 |->
      prdata[6] == $past(sysclk_from_osc))
      else $error("control bit 6 differs from clock status input");
   // Oscillator enable moves only on a committed control write
   osc_by_write_a: assert property ($changed(osc_amp_enable) |->
      $past(pready && pwrite && paddr == 12'h000))
      else $error("oscillator enable changed without control write");
   pin0_gate_a: assert property (pin0_oe == (!osc_amp_enable && !port_c_direction[0]))
      else $error("pin 0 enable wrong");
   pin1_gate_a: assert property (pin1_oe == (!osc_amp_enable && !port_c_direction[1]))
      else $error("pin 1 enable wrong");
   pin_read_zero_a: assert property (osc_amp_enable && $past(osc_amp_enable) |->
      port_c_read == 2'h0)
      else $error("pins read nonzero while oscillator enabled");
endmodule // tmr_timer_props

bind tmr_timer_top tmr_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sysclk_from_osc(sysclk_from_osc), .port_c_direction(port_c_direction),
   .pin0_oe(pin0_oe), .pin1_oe(pin1_oe), .osc_amp_enable(osc_amp_enable),
   .port_c_read(port_c_read));

// ===== testbench/tb_top.sv
// Self-checking bench for the timer top, driven through APB calls.
// Assumes one 20 MHz clock; pins are driven slowly against the synchronisers.
`timescale 1ns/100ps
module tb_top;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg sysc = 0, ext = 0, osc = 0;
   reg [1:0] dir = 2'h3, pout = 2'h2;
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [1:0] pcr;
   wire oe0, oe1, oamp, out0, out1;
   reg [31:0] rdat;
   reg rerr;
   integer n_errors = 0, comparisons = 0, cycles = 0, p, m;

   tmr_timer_top dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .sysclk_from_osc(sysc),
      .external_count_input(ext), .osc_input_pin(osc), .port_c_direction(dir),
      .port_c_out(pout), .pin0_out(out0), .pin0_oe(oe0), .pin1_out(out1), .pin1_oe(oe1),
      .osc_amp_enable(oamp), .port_c_read(pcr));

   always #25 pclk = ~pclk;

   // Hang guard, far above the expected run length
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         n_errors = n_errors + 1;
         finish_test;
      end
   end

   task finish_test;
   begin
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask

   task check(input [31:0] got, input [31:0] exp);
   begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   // Setup, access, hold until pready; data taken at that edge
   task apb(input w, input [11:0] a, input [7:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task wr(input [11:0] a, input [7:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input [11:0] a, input [7:0] e);
   begin
      apb(1'b0, a, 8'h00);
      check(rdat, {24'h0, e});
   end
   endtask

   // Three pulses starting low: first rise lacks a prior fall
   task pulses(input sel);
   begin
      repeat (3)
      begin
         repeat (12) @(posedge pclk);
         if (sel) osc <= 1'b1; else ext <= 1'b1;
         repeat (12) @(posedge pclk);
         check({30'h0, pcr}, sel ? 32'h0 : 32'h1);
         // Port out bits pass through; oscillator takes the drive away
         check({27'h0, out1, out0, oamp, oe1, oe0}, sel ? 32'h14 : 32'h13);
         if (sel) osc <= 1'b0; else ext <= 1'b0;
      end
      repeat (12) @(posedge pclk);
   end
   endtask

   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (p = 0; p < 6; p = p + 1)
         rd(p * 4, 8'h00);
      apb(1'b0, 12'h018, 8'h00);
      check({31'h0, rerr}, 32'h1);
      wr(12'h018, 8'h55);
      check({31'h0, rerr}, 32'h1);
      // Status bit is read-only and live
      wr(12'h000, 8'hf4);
      rd(12'h000, 8'hb4);
      sysc <= 1'b1;
      rd(12'h000, 8'hf4);
      sysc <= 1'b0;
      wr(12'h000, 8'h00);
      // Internal source, every prescale code, five ticks in the window
      for (p = 0; p < 4; p = p + 1)
      begin
         wr(12'h004, 8'h00);
         wr(12'h008, 8'h00);
         wr(12'h000, {2'h0, p[1:0], 4'h1});
         repeat (4 * (1 << p) * 5 - 3) @(posedge pclk);
         wr(12'h000, 8'h00);
         apb(1'b0, 12'h004, 8'h00);
         check({31'h0, rdat[7:0] >= 4 && rdat[7:0] <= 6}, 32'h1);
         repeat (40) @(posedge pclk);
         rd(12'h004, rdat[7:0]);
      end
      // External sync, external bypass, oscillator pin; both pins set as outputs
      dir <= 2'h0;
      for (m = 0; m < 3; m = m + 1)
      begin
         wr(12'h004, 8'h00);
         wr(12'h008, 8'h00);
         wr(12'h000, m == 0 ? 8'h03 : (m == 1 ? 8'h07 : 8'h0b));
         pulses(m == 2);
         wr(12'h000, 8'h00);
         rd(12'h004, 8'h02);
      end
      // Off while high, then on while low: the next rise must not count
      wr(12'h004, 8'h00);
      wr(12'h000, 8'h03);
      pulses(1'b0);
      ext <= 1'b1;
      repeat (12) @(posedge pclk);
      wr(12'h000, 8'h02);
      ext <= 1'b0;
      repeat (12) @(posedge pclk);
      wr(12'h000, 8'h03);
      ext <= 1'b1;
      repeat (12) @(posedge pclk);
      wr(12'h000, 8'h00);
      rd(12'h004, 8'h03);
      // 1:2 on the pin; a count write drops the half-way prescale count
      wr(12'h000, 8'h13);
      ext <= 1'b0;
      repeat (12) @(posedge pclk);
      ext <= 1'b1;
      repeat (12) @(posedge pclk);
      wr(12'h000, 8'h12);
      wr(12'h004, 8'h00);
      wr(12'h000, 8'h13);
      ext <= 1'b0;
      repeat (12) @(posedge pclk);
      ext <= 1'b1;
      repeat (12) @(posedge pclk);
      rd(12'h004, 8'h00);
      ext <= 1'b0;
      repeat (12) @(posedge pclk);
      ext <= 1'b1;
      repeat (12) @(posedge pclk);
      wr(12'h000, 8'h00);
      rd(12'h004, 8'h01);
      // Wrap with interrupt enabled, then mask and clear
      wr(12'h014, 8'h01);
      wr(12'h008, 8'hff);
      wr(12'h004, 8'hfe);
      wr(12'h000, 8'h01);
      repeat (20) @(posedge pclk);
      wr(12'h000, 8'h00);
      check({31'h0, irq}, 32'h1);
      rd(12'h008, 8'h00);
      wr(12'h00c, 8'h00);
      rd(12'h00c, 8'h01);
      wr(12'h014, 8'h00);
      // Enable lands at the commit edge; look one edge later
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      wr(12'h010, 8'h01);
      rd(12'h00c, 8'h00);
      rd(12'h010, 8'h00);
      wr(12'h014, 8'h01);
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      // Byte mode writes high live; wide mode goes through the buffer
      wr(12'h008, 8'h77);
      wr(12'h004, 8'h00);
      rd(12'h008, 8'h77);
      wr(12'h000, 8'h80);
      wr(12'h008, 8'h00);
      rd(12'h004, 8'h00);
      rd(12'h008, 8'h77);
      wr(12'h008, 8'h12);
      wr(12'h004, 8'h34);
      wr(12'h000, 8'h00);
      rd(12'h008, 8'h12);
      rd(12'h004, 8'h34);
      finish_test;
   end
endmodule // tb_top
